// ==== ccpsp_pkg.sv ====
// package: offsets, reset values and carriers of the pwm generator
`default_nettype none
package ccpsp_pkg;
  localparam int unsigned N_TMR = 3;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TSEL_LO = 8'h04;
  localparam logic [7:0] OFF_TSEL_HI = 8'h08;
  localparam logic [7:0] OFF_DUTY_WR = 8'h0c;
  localparam logic [7:0] OFF_DUTY_BUF = 8'h10;
  localparam logic [7:0] OFF_PIN_DIR = 8'h14;
  localparam logic [7:0] OFF_MISC = 8'h18;
  // timer i sits at TMR_BASE + i * 16
  localparam logic [7:0] TMR_BASE = 8'h20;
  localparam logic [3:0] TMR_PRD = 4'h0;
  localparam logic [3:0] TMR_CON = 4'h4;
  localparam logic [3:0] TMR_CNT = 4'h8;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [1:0] RST_TSEL = 2'h0;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [9:0] RST_DUTY_BUF = 10'h000;
  localparam logic [7:0] RST_PRD = 8'hff;
  localparam logic [7:0] RST_TCON = 8'h00;
  localparam logic [7:0] RST_CNT = 8'h00;
  localparam logic [3:0] RST_PIN_DIR = 4'hf;
  localparam logic [3:0] RST_STEER = 4'h1;
  // fields
  localparam logic [1:0] CM_PWM = 2'h3;
  localparam int unsigned TCON_RUN = 2;
  localparam int unsigned MISC_SLEEP = 0;
  localparam logic [1:0] PS_1 = 2'h0;
  localparam logic [1:0] PS_4 = 2'h1;
  // one timer step is one instruction cycle of four clocks times prescale
  localparam int unsigned INSTR_CLKS = 4;
  localparam logic [5:0] LAST_PS1 = 6'(INSTR_CLKS * 1 - 1);
  localparam logic [5:0] LAST_PS4 = 6'(INSTR_CLKS * 4 - 1);
  localparam logic [5:0] LAST_PS16 = 6'(INSTR_CLKS * 16 - 1);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OM_SINGLE = 2'b00,
    OM_FWD = 2'b01,
    OM_HALF = 2'b10,
    OM_REV = 2'b11
  } ccpsp_omode_t;

  typedef struct packed {
    logic run;
    logic freeze;
    logic [1:0] presc;
    logic [7:0] period;
    logic wr_cnt;
    logic [7:0] wr_val;
  } ccpsp_tcfg_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [9:0] tbase;
    logic wrap;
  } ccpsp_tstat_t;

  typedef struct packed {
    logic [5:0] pc;
    ccpsp_tstat_t st;
  } ccpsp_tmr_t;
endpackage
`default_nettype wire

// ==== ccpsp_timer.sv ====
// module: one 8-bit period timer with prescaler and 10-bit time base
`default_nettype none
module ccpsp_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // configuration and state
  input wire ccpsp_pkg::ccpsp_tcfg_t cfg,
  output ccpsp_pkg::ccpsp_tstat_t stat
);
  import ccpsp_pkg::*;

  ccpsp_tmr_t q, d;
  logic [5:0] last;

  assign stat = q.st;

  always_comb begin
    d = q;
    // a wrap that meets sleep waits for wake-up rather than being lost
    if (!cfg.freeze || cfg.wr_cnt) begin
      d.st.wrap = 1'b0;
    end
    case (cfg.presc)
      PS_1: last = LAST_PS1;
      PS_4: last = LAST_PS4;
      default: last = LAST_PS16;
    endcase
    if (cfg.wr_cnt) begin
      d.st.cnt = cfg.wr_val;
      d.pc = 6'h00;
    end else if (cfg.run && !cfg.freeze) begin
      if (q.pc >= last) begin
        d.pc = 6'h00;
        if (q.st.cnt == cfg.period) begin
          d.st.cnt = RST_CNT;
          d.st.wrap = 1'b1;
        end else begin
          d.st.cnt = q.st.cnt + 8'h01;
        end
      end else begin
        d.pc = q.pc + 6'h01;
      end
    end
    // low bits: clock phase at 1:1, upper prescaler bits otherwise
    case (cfg.presc)
      PS_1: d.st.tbase = {d.st.cnt, d.pc[1:0]};
      PS_4: d.st.tbase = {d.st.cnt, d.pc[3:2]};
      default: d.st.tbase = {d.st.cnt, d.pc[5:4]};
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wrap_zero;
    stat.wrap |-> stat.cnt == 8'h00 && stat.tbase == 10'h000;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("wrap without cleared timer");

  property p_step;
    cfg.run && !cfg.freeze && !cfg.wr_cnt && q.pc < last |=> $stable(stat.cnt);
  endproperty
  a_step: assert property (p_step) else $error("timer stepped early");

  property p_freeze;
    cfg.freeze && !cfg.wr_cnt |=> $stable(q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("timer moved in sleep");
endmodule
`default_nettype wire

// ==== ccpsp_pwm.sv ====
// module: standard and enhanced pwm channel with an axi4-lite register slave
// Operation
// - Period time base comes from one of three 8-bit timers, picked by 2-bit select.
// - Period is (period value + 1) times four clocks times prescale.
// - After count equals period: clear timer, set pin unless 0%, load duty.
// - Timer postscaler has no effect on pwm period.
// - Duty is 10 bits: 8 high bits in a register, 2 low in control.
// - Duty may be written anytime; takes effect only at period end.
// - Buffered duty-high register is read-only while pwm runs.
// - Duty double-buffered: buffer register plus hidden 2-bit latch.
// - Time base is timer count plus clock phase or prescaler bits.
// - Pin clears when time base equals buffered duty.
// - Duty longer than period leaves the pin set all period.
// - Resolution is log2 of 4 times (period + 1), ten bits max.
// - Prescale selectable as 1, 4 or 16.
// - Sleep stops the timer and freezes state; outputs hold their level.
// - Reset makes pins inputs and returns registers to reset values.
// - Zero in the whole control register releases the pins.
// - Up to four pins in four output modes, picked by 2-bit field.
// - Pin polarity chosen through the channel mode field.
// - First enable waits for a new period before any waveform.
// - Pins unused by the mode stay free for other functions.
// - Half-bridge: waveform on first pin, complement on second.
// - Full-bridge forward: first active, fourth modulated, others inactive.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`default_nettype none
module ccpsp_pwm #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // output pins a..d, enable high while driven
  output logic [3:0] pwm_out,
  output logic [3:0] pwm_oe
);
  import ccpsp_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_en;
    logic [7:0] ctrl;
    logic [1:0] tsel;
    logic [7:0] duty_hi;
    logic [9:0] duty_buf;
    logic [3:0] pin_dir;
    logic [3:0] steer;
    logic sleep;
    logic active;
    logic lvl;
    logic [3:0] pin;
    logic [3:0] oe;
    logic [N_TMR-1:0][7:0] prd;
    logic [N_TMR-1:0][7:0] tcon;
  } ccpsp_regs_t;

  ccpsp_regs_t q, d;
  ccpsp_tcfg_t tcfg [N_TMR];
  ccpsp_tstat_t tstat [N_TMR];
  ccpsp_tstat_t ts;
  logic pwm_on;
  logic do_wr;
  logic [7:0] t_off;
  logic t_hit;
  logic [1:0] t_idx;
  logic [9:0] nxt_duty;
  logic [3:0] lg;
  logic [3:0] used;
  logic [7:0] ra;
  logic [7:0] rv;
  logic rerr;

  genvar gi;
  generate
    for (gi = 0; gi < N_TMR; gi++) begin : g_tmr
      ccpsp_timer u_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(tcfg[gi]),
        .stat(tstat[gi])
      );
    end
  endgenerate

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = q.rdata;
  assign pwm_out = q.pin;
  assign pwm_oe = q.oe;

  always_comb begin
    d = q;
    pwm_on = q.ctrl[3:2] == CM_PWM;
    do_wr = q.aw_have && q.w_have && !q.bvalid;
    t_off = q.aw_addr - TMR_BASE;
    t_idx = t_off[5:4];
    t_hit = q.aw_addr >= TMR_BASE && t_off[7:6] == 2'h0 && 32'(t_idx) < N_TMR;
    nxt_duty = {q.duty_hi, q.ctrl[5:4]};
    lg = 4'h0;
    used = 4'h0;
    ra = araddr[7:0];
    rv = 8'h00;
    rerr = 1'b0;
    ts = '0;
    // select 3 names no timer, so the channel never starts a period
    if (32'(q.tsel) < N_TMR) begin
      ts = tstat[q.tsel];
    end
    for (int i = 0; i < N_TMR; i++) begin
      tcfg[i].run = q.tcon[i][TCON_RUN];
      tcfg[i].freeze = q.sleep;
      tcfg[i].presc = q.tcon[i][1:0];
      tcfg[i].period = q.prd[i];
      tcfg[i].wr_cnt = do_wr && q.w_en && t_hit && t_idx == 2'(i) && t_off[3:0] == TMR_CNT;
      tcfg[i].wr_val = q.w_data;
    end

    // write address and data are taken in either order
    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr[7:0];
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = wdata[7:0];
      d.w_en = wstrb[0];
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (do_wr) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.aw_addr == OFF_CTRL) begin
        if (q.w_en) begin
          d.ctrl = q.w_data;
        end
      end else if (q.aw_addr == OFF_TSEL_LO) begin
        if (q.w_en) begin
          d.tsel = q.w_data[1:0];
        end
      end else if (q.aw_addr == OFF_TSEL_HI) begin
        d.bresp = RESP_OKAY;
      end else if (q.aw_addr == OFF_DUTY_WR) begin
        if (q.w_en) begin
          d.duty_hi = q.w_data;
        end
      end else if (q.aw_addr == OFF_DUTY_BUF) begin
        if (q.w_en && !pwm_on) begin
          d.duty_buf[9:2] = q.w_data;
        end
      end else if (q.aw_addr == OFF_PIN_DIR) begin
        if (q.w_en) begin
          d.pin_dir = q.w_data[3:0];
        end
      end else if (q.aw_addr == OFF_MISC) begin
        if (q.w_en) begin
          d.sleep = q.w_data[MISC_SLEEP];
          d.steer = q.w_data[7:4];
        end
      end else if (t_hit && t_off[3:0] == TMR_PRD) begin
        if (q.w_en) begin
          d.prd[t_idx] = q.w_data;
        end
      end else if (t_hit && t_off[3:0] == TMR_CON) begin
        if (q.w_en) begin
          d.tcon[t_idx] = {1'b0, q.w_data[6:0]};
        end
      end else if (t_hit && t_off[3:0] == TMR_CNT) begin
        d.bresp = RESP_OKAY;
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end

    // read side: one beat, answer registered on the same edge that takes the address
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      if (ra == OFF_CTRL) begin
        rv = q.ctrl;
      end else if (ra == OFF_TSEL_LO) begin
        rv = {6'h00, q.tsel};
      end else if (ra == OFF_TSEL_HI) begin
        rv = 8'h00;
      end else if (ra == OFF_DUTY_WR) begin
        rv = q.duty_hi;
      end else if (ra == OFF_DUTY_BUF) begin
        rv = q.duty_buf[9:2];
      end else if (ra == OFF_PIN_DIR) begin
        rv = {4'h0, q.pin_dir};
      end else if (ra == OFF_MISC) begin
        rv = {q.steer, 3'h0, q.sleep};
      end else if (ra >= TMR_BASE && ra < TMR_BASE + 8'(N_TMR * 16)) begin
        // postscale bits are kept for software only, never used here
        case (ra[3:0])
          TMR_PRD: rv = q.prd[2'(ra[5:4] - 2'h2)];
          TMR_CON: rv = q.tcon[2'(ra[5:4] - 2'h2)];
          TMR_CNT: rv = tstat[2'(ra[5:4] - 2'h2)].cnt;
          default: rerr = 1'b1;
        endcase
      end else begin
        rerr = 1'b1;
      end
      d.rvalid = 1'b1;
      d.rdata = {24'h000000, rv};
      d.rresp = rerr ? RESP_SLVERR : RESP_OKAY;
    end

    // waveform; sleep freezes all of it so pins hold their level
    if (!q.sleep) begin
      if (!pwm_on) begin
        d.active = 1'b0;
        d.lvl = 1'b0;
      end else if (ts.wrap) begin
        d.duty_buf = nxt_duty;
        d.active = 1'b1;
        d.lvl = nxt_duty != 10'h000;
      end else if (q.active && ts.tbase == q.duty_buf) begin
        // a duty above the period never matches, so the pin stays set
        d.lvl = 1'b0;
      end
      // logical levels before polarity, held inactive until first period
      case (ccpsp_omode_t'(q.ctrl[7:6]))
        OM_SINGLE: begin
          lg = {4{d.lvl}};
          used = q.steer;
        end
        OM_HALF: begin
          lg = {2'b00, ~d.lvl, d.lvl};
          used = 4'b0011;
        end
        OM_FWD: begin
          lg = {d.lvl, 2'b00, 1'b1};
          used = 4'b1111;
        end
        default: begin
          lg = {1'b0, 1'b1, d.lvl, 1'b0};
          used = 4'b1111;
        end
      endcase
      if (!d.active) begin
        lg = 4'h0;
      end
      // mode bit 1 inverts a and c, bit 0 inverts b and d
      d.pin = lg ^ {q.ctrl[0], q.ctrl[1], q.ctrl[0], q.ctrl[1]};
      d.oe = used & ~q.pin_dir & {4{pwm_on}};
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= RST_CTRL;
      q.tsel <= RST_TSEL;
      q.duty_hi <= RST_DUTY;
      q.duty_buf <= RST_DUTY_BUF;
      q.pin_dir <= RST_PIN_DIR;
      q.steer <= RST_STEER;
      q.prd <= {N_TMR{RST_PRD}};
      q.tcon <= {N_TMR{RST_TCON}};
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_period_end;
    pwm_on && ts.wrap && !q.sleep;
  endsequence

  property p_duty_load;
    s_period_end |=> q.duty_buf == $past(nxt_duty) && q.active;
  endproperty
  a_duty_load: assert property (p_duty_load) else $error("duty not loaded at period end");

  property p_set_pin;
    s_period_end and nxt_duty != 10'h000 |=> q.lvl;
  endproperty
  a_set_pin: assert property (p_set_pin) else $error("pin not set at period start");

  property p_zero_duty;
    s_period_end and nxt_duty == 10'h000 |=> !q.lvl;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("pin set at zero duty");

  property p_match_clear;
    pwm_on && !q.sleep && q.active && !ts.wrap && ts.tbase == q.duty_buf |=> !q.lvl;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("pin not cleared on match");

  property p_hold_buf;
    pwm_on && !ts.wrap |=> $stable(q.duty_buf);
  endproperty
  a_hold_buf: assert property (p_hold_buf) else $error("duty buffer moved mid period");

  property p_sleep_hold;
    q.sleep |=> $stable(q.pin) && $stable(q.oe) && $stable(q.lvl);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("outputs moved in sleep");

  property p_release;
    !$past(q.sleep) && $past(q.ctrl) == 8'h00 |-> pwm_oe == 4'h0;
  endproperty
  a_release: assert property (p_release) else $error("pins driven with control cleared");

  property p_reset;
    disable iff (1'b0) !aresetn |=> pwm_oe == 4'h0 && q.pin_dir == RST_PIN_DIR;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left pins driven");

  property p_half;
    !$past(q.sleep) && $stable(q.ctrl) && q.ctrl[7:6] == OM_HALF && q.ctrl[1:0] == 2'h0 && q.active
      |-> pwm_out[1:0] == {~q.lvl, q.lvl};
  endproperty
  a_half: assert property (p_half) else $error("half bridge pair not complementary");

  property p_fwd;
    !$past(q.sleep) && $stable(q.ctrl) && q.ctrl[7:6] == OM_FWD && q.ctrl[1:0] == 2'h0 && q.active
      |-> pwm_out == {q.lvl, 3'b001};
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward bridge pattern wrong");

  property p_wr_resp;
    q.aw_have && q.w_have && !q.bvalid |=> bvalid ##0 !awready && !wready;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer missing");
endmodule
`default_nettype wire

// ==== ccpsp_load.sv ====
// behavioural load on pin a that measures high time and period in clocks
`default_nettype none
module ccpsp_load (
  // clock
  input wire logic aclk,
  // pin a driver and its enable
  input wire logic drv,
  input wire logic oe,
  // last complete measurements
  output logic [15:0] high_cyc,
  output logic [15:0] per_cyc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin;
  logic prev_q = 1'b0;
  logic [15:0] cnt_q = 16'h0000;
  logic [15:0] hcnt_q = 16'h0000;
  // pull-down on the load, so a released pin reads low, not its last value
  assign pin = oe ? drv : 1'b0;
  initial begin
    high_cyc = 16'h0000;
    per_cyc = 16'h0000;
  end
  always @(posedge aclk) begin
    prev_q <= pin;
    if (pin && !prev_q) begin
      per_cyc <= cnt_q;
      cnt_q <= 16'h0001;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
    if (pin) begin
      hcnt_q <= prev_q ? hcnt_q + 16'h0001 : 16'h0001;
    end
    if (!pin && prev_q) begin
      high_cyc <= hcnt_q;
    end
  end
endmodule
`default_nettype wire

// ==== ccp_standard_pwm_generator_test.sv ====
// self-checking bench for the pwm generator
`default_nettype none
module ccp_standard_pwm_generator_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ccpsp_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, rd_q;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, pwm_out, pwm_oe;
  logic [1:0] bresp, rresp, rs_q;
  logic [15:0] high_cyc, per_cyc;
  int num_errors = 0;
  int comparisons = 0;

  ccpsp_pwm DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
  ccpsp_load LOAD (.aclk(aclk), .drv(pwm_out[0]), .oe(pwm_oe[0]), .high_cyc(high_cyc), .per_cyc(per_cyc));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd_q = rdata[7:0];
    rs_q = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(what, {24'h0, e}, {24'h0, rd_q});
  endtask

  // long enough for two clean periods after any change
  task automatic meas(input int h, input int p);
    repeat (3 * p + 8) @(posedge aclk);
    chk("high time", h, {16'h0, high_cyc});
    chk("period", p, {16'h0, per_cyc});
  endtask

  task automatic hold(input logic lvl, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge aclk);
      if (pwm_out[0] !== lvl) ok = 1'b0;
    end
    chk("held level", 1, {31'h0, ok});
  endtask

  task automatic mode(input logic [7:0] c, input logic [3:0] m, input logic [3:0] v, input logic [3:0] oe_e);
    logic ok;
    ok = 1'b1;
    wr(OFF_CTRL, c);
    repeat (32) @(posedge aclk);
    repeat (32) begin
      @(posedge aclk);
      if ((pwm_out & m) !== v || pwm_oe !== oe_e) ok = 1'b0;
      if (c[7:6] == 2'b10 && pwm_out[1] !== ~pwm_out[0]) ok = 1'b0;
    end
    chk("mode pins", 1, {31'h0, ok});
  endtask

  task automatic t_reset();
    rchk("control", OFF_CTRL, RST_CTRL);
    rchk("timer select", OFF_TSEL_LO, 8'h00);
    rchk("period", TMR_BASE, RST_PRD);
    rchk("timer control", 8'h24, RST_TCON);
    rchk("pin direction", OFF_PIN_DIR, 8'h0f);
    chk("oe", 0, {28'h0, pwm_oe});
    wr(8'hfc, 8'h5a, RESP_SLVERR);
    rd(8'hfc);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rs_q});
    $display("test reset done");
  endtask

  task automatic t_period();
    wr(TMR_BASE, 8'h03);
    wr(OFF_CTRL, 8'h1c);
    wr(OFF_DUTY_WR, 8'h02);
    wr(OFF_PIN_DIR, 8'h0e);
    for (int i = 0; i < 3; i++) begin
      wr(8'h24, 8'h04 | 8'(i));
      meas(9 * (4 ** i), 16 * (4 ** i));
    end
    // postscale bits set, prescale 4
    wr(8'h24, 8'h7d);
    meas(36, 64);
    wr(8'h30, 8'h07);
    wr(8'h34, 8'h04);
    wr(OFF_TSEL_LO, 8'h01);
    meas(9, 32);
    wr(OFF_TSEL_LO, 8'h00);
    $display("test period done");
  endtask

  task automatic t_buffer();
    wr(OFF_CTRL, 8'h0c);
    wr(TMR_BASE, 8'hff);
    wr(8'h24, 8'h06);
    wr(8'h28, 8'h00);
    wr(OFF_DUTY_WR, 8'h40);
    rchk("duty buffer", OFF_DUTY_BUF, 8'h02);
    wr(OFF_DUTY_BUF, 8'h55);
    rchk("duty buffer", OFF_DUTY_BUF, 8'h02);
    repeat (16400) @(posedge aclk);
    rchk("duty buffer", OFF_DUTY_BUF, 8'h40);
    wr(8'h24, 8'h04);
    wr(OFF_DUTY_WR, 8'hff);
    wr(OFF_CTRL, 8'h3c);
    meas(1023, 1024);
    $display("test buffer done");
  endtask

  task automatic t_edges();
    wr(TMR_BASE, 8'h03);
    // count may sit above the new period and would run on to overflow
    wr(8'h28, 8'h00);
    wr(OFF_CTRL, 8'h0c);
    wr(OFF_DUTY_WR, 8'h00);
    repeat (40) @(posedge aclk);
    hold(1'b0, 48);
    wr(OFF_DUTY_WR, 8'hff);
    repeat (40) @(posedge aclk);
    hold(1'b1, 48);
    $display("test edges done");
  endtask

  task automatic t_modes();
    wr(OFF_DUTY_WR, 8'h02);
    wr(OFF_CTRL, 8'h1e);
    meas(7, 16);
    wr(OFF_PIN_DIR, 8'h00);
    mode(8'h1c, 4'h0, 4'h0, 4'h1);
    mode(8'h9c, 4'h0, 4'h0, 4'h3);
    mode(8'h5c, 4'h7, 4'h1, 4'hf);
    mode(8'hdc, 4'h9, 4'h0, 4'hf);
    mode(8'hdc, 4'h4, 4'h4, 4'hf);
    $display("test modes done");
  endtask

  task automatic t_sleep();
    logic [7:0] cnt;
    logic [3:0] pins;
    wr(OFF_CTRL, 8'h1c);
    wr(OFF_MISC, 8'h11);
    rd(8'h28);
    cnt = rd_q;
    pins = pwm_out;
    repeat (200) @(posedge aclk);
    rchk("frozen count", 8'h28, cnt);
    chk("frozen pins", {28'h0, pins}, {28'h0, pwm_out});
    wr(OFF_MISC, 8'h10);
    meas(9, 16);
    $display("test sleep done");
  endtask

  task automatic t_release();
    wr(OFF_CTRL, 8'h00);
    @(posedge aclk);
    chk("released oe", 0, {28'h0, pwm_oe});
    wr(OFF_CTRL, 8'h1c);
    repeat (40) @(posedge aclk);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("oe after reset", 0, {28'h0, pwm_oe});
    rchk("control", OFF_CTRL, RST_CTRL);
    rchk("pin direction", OFF_PIN_DIR, 8'h0f);
    $display("test release done");
  endtask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_period();
    t_buffer();
    t_edges();
    t_modes();
    t_sleep();
    t_release();
    finish_test();
  end

  // the whole run needs about 22000 cycles
  initial begin
    repeat (100000) @(posedge aclk);
    num_errors++;
    $display("BAD watchdog expected done seen timeout");
    finish_test();
  end
endmodule
`default_nettype wire
